// ### rtl/sld_pkg.sv
// Constants for the serial-in latched sink driver.
// Assumes one 100 MHz core clock; all pins are asynchronous to it.
// Function
// - Each rising shift clock edge loads the data input into stage 0 and moves bits on.
// - An eight-stage serial-in parallel-out shift register feeds an eight-bit latch.
// - Each rising latch clock edge copies every shift stage into its latch bit.
// - While the clear input is low, shift register, latch and remainder are cleared.
// - Latch contents reach the sink outputs only while the clear input is high.
// - Enable low drives each sink from its latch bit; enable high turns all sinks off.
// - The last shift stage appears on the cascade output for the next device.
// - A check remainder is kept over shifted bits and six bits of it are read back.
package sld_pkg;

    // =====================================================
    // Widths
    localparam int SR_W  = 8;
    localparam int CRC_W = 6;
    localparam int PIN_W = 6;

    // =====================================================
    // Synchronised pin positions
    localparam int PIN_SCLK = 0;
    localparam int PIN_SDI  = 1;
    localparam int PIN_LCLK = 2;
    localparam int PIN_CLRN = 3;
    localparam int PIN_ENN  = 4;
    localparam int PIN_RBM  = 5;

    // =====================================================
    // Reset values
    localparam logic [PIN_W-1:0] PIN_RST   = 6'h10;
    localparam logic [SR_W-1:0]  SR_RST    = 8'h00;
    localparam logic [CRC_W-1:0] CRC_INIT  = 6'h00;
    localparam logic [CRC_W-1:0] CRC_POLY  = 6'h03;
    localparam logic [SR_W-1:0]  SINK_LOW  = 8'h00;

endpackage

// ### rtl/sld_buf.sv
// Two-entry read-back buffer with valid and ready on both sides.
// Assumes the filler and the drain share the core clock.
`timescale 1ns/100ps
`default_nettype none
module sld_buf #(
    parameter int DW = sld_pkg::CRC_W
) (
    // Clock and reset
    input  wire logic          core_clk_i,
    input  wire logic          sys_rst_i,
    // Fill side
    input  wire logic [DW-1:0] in_data_i,
    input  wire logic          in_valid_i,
    output logic               in_ready_o,
    // Drain side
    output logic [DW-1:0]      out_data_o,
    output logic               out_valid_o,
    input  wire logic          out_ready_i
);

    typedef struct packed {
        logic [DW-1:0] head;
        logic          head_v;
        logic [DW-1:0] spare;
        logic          spare_v;
    } sld_buf_t;

    sld_buf_t st_r;
    sld_buf_t st_nxt;

    logic pop;
    logic push;

    // =====================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        pop    = st_r.head_v & out_ready_i;
        push   = in_valid_i & ~st_r.spare_v;
        if (pop) begin
            st_nxt.head    = st_r.spare;
            st_nxt.head_v  = st_r.spare_v;
            st_nxt.spare_v = 1'b0;
        end
        if (push) begin
            if (!st_nxt.head_v) begin
                st_nxt.head   = in_data_i;
                st_nxt.head_v = 1'b1;
            end else begin
                st_nxt.spare   = in_data_i;
                st_nxt.spare_v = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready_o  = ~st_r.spare_v;
    assign out_data_o  = st_r.head;
    assign out_valid_o = st_r.head_v;

    // =====================================================
    // Checks
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    buf_no_loss_a: assert property (in_valid_i && in_ready_o && !out_valid_o |=> out_valid_o
                                    && out_data_o == $past(in_data_i))
        else $error("buffer lost a pushed word");

endmodule
`default_nettype wire

// ### rtl/sld_top.sv
// Serial-in latched sink driver: shift chain, storage latch, sink drives.
// Assumes all pin inputs are asynchronous and far slower than the core clock.
`timescale 1ns/100ps
`default_nettype none
module sld_top (
    // Clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       sys_rst_i,
    // Serial link pins
    input  wire logic                       shift_clock_i,
    input  wire logic                       shift_data_input_i,
    input  wire logic                       latch_clock_i,
    input  wire logic                       register_clear_n_i,
    input  wire logic                       drive_enable_n_i,
    input  wire logic                       readback_mode_i,
    // Cascade
    output logic                            cascade_output_o,
    // Open-drain sinks
    output logic [sld_pkg::SR_W-1:0]        sink_output_o,
    output logic [sld_pkg::SR_W-1:0]        sink_output_oe_o,
    // Read-back stream
    output logic [sld_pkg::CRC_W-1:0]       readback_data_o,
    output logic                            readback_valid_o,
    input  wire logic                       readback_ready_i
);

    typedef struct packed {
        logic [sld_pkg::PIN_W-1:0] meta;
        logic [sld_pkg::PIN_W-1:0] sync;
        logic                      sclk_q;
        logic                      lclk_q;
        logic [sld_pkg::SR_W-1:0]  shreg;
        logic [sld_pkg::SR_W-1:0]  latch;
        logic [sld_pkg::CRC_W-1:0] crc;
        logic                      rb_pend;
        logic [sld_pkg::CRC_W-1:0] rb_word;
        logic                      casc;
        logic [sld_pkg::SR_W-1:0]  sink_oe;
    } sld_state_t;

    sld_state_t st_r;
    sld_state_t st_nxt;

    logic                      sclk_rise;
    logic                      lclk_rise;
    logic                      clr_n;
    logic                      en_n;
    logic                      sdi;
    logic                      rb_mode;
    logic                      buf_ready;
    logic [sld_pkg::CRC_W-1:0] crc_step;
    logic                      crc_fb;

    // =====================================================
    // Decoded synchronised pins
    always_comb begin
        sclk_rise = st_r.sync[sld_pkg::PIN_SCLK] & ~st_r.sclk_q;
        lclk_rise = st_r.sync[sld_pkg::PIN_LCLK] & ~st_r.lclk_q;
        clr_n     = st_r.sync[sld_pkg::PIN_CLRN];
        en_n      = st_r.sync[sld_pkg::PIN_ENN];
        sdi       = st_r.sync[sld_pkg::PIN_SDI];
        rb_mode   = st_r.sync[sld_pkg::PIN_RBM];
        crc_fb    = st_r.crc[sld_pkg::CRC_W-1] ^ sdi;
        crc_step  = {st_r.crc[sld_pkg::CRC_W-2:0], 1'b0}
                    ^ (crc_fb ? sld_pkg::CRC_POLY : sld_pkg::CRC_INIT);
    end

    // =====================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Two-stage synchronisers, edge history from the second stage
        st_nxt.meta   = {readback_mode_i, drive_enable_n_i, register_clear_n_i,
                         latch_clock_i, shift_data_input_i, shift_clock_i};
        st_nxt.sync   = st_r.meta;
        st_nxt.sclk_q = st_r.sync[sld_pkg::PIN_SCLK];
        st_nxt.lclk_q = st_r.sync[sld_pkg::PIN_LCLK];

        if (!clr_n) begin
            st_nxt.shreg   = sld_pkg::SR_RST;
            st_nxt.latch   = sld_pkg::SR_RST;
            st_nxt.crc     = sld_pkg::CRC_INIT;
            st_nxt.rb_pend = 1'b0;
        end else begin
            // Latch samples the chain before this cycle's shift
            if (lclk_rise) begin
                st_nxt.latch = st_r.shreg;
            end
            if (sclk_rise) begin
                st_nxt.shreg = {st_r.shreg[sld_pkg::SR_W-2:0], sdi};
                st_nxt.crc   = crc_step;
            end
            // Read-back request waits while the buffer is full
            if (st_r.rb_pend && buf_ready) begin
                st_nxt.rb_pend = 1'b0;
            end
            if (lclk_rise && rb_mode && !st_r.rb_pend) begin
                st_nxt.rb_pend = 1'b1;
                st_nxt.rb_word = st_r.crc;
                // Same-cycle shift bit starts the new remainder from zero
                st_nxt.crc     = (sclk_rise && sdi) ? sld_pkg::CRC_POLY : sld_pkg::CRC_INIT;
            end
        end

        st_nxt.casc = st_r.shreg[sld_pkg::SR_W-1];
        // Sinks follow the latch only with clear high and enable low
        if (!clr_n || en_n) begin
            st_nxt.sink_oe = sld_pkg::SINK_LOW;
        end else begin
            st_nxt.sink_oe = st_r.latch;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_r         <= '0;
            st_r.meta    <= sld_pkg::PIN_RST;
            st_r.sync    <= sld_pkg::PIN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =====================================================
    // Read-back buffer
    sld_buf #(
        .DW (sld_pkg::CRC_W)
    ) u_buf (
        .core_clk_i  (core_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_data_i   (st_r.rb_word),
        .in_valid_i  (st_r.rb_pend),
        .in_ready_o  (buf_ready),
        .out_data_o  (readback_data_o),
        .out_valid_o (readback_valid_o),
        .out_ready_i (readback_ready_i)
    );

    // =====================================================
    // Outputs
    assign cascade_output_o = st_r.casc;
    assign sink_output_o    = sld_pkg::SINK_LOW;
    assign sink_output_oe_o = st_r.sink_oe;

    // =====================================================
    // Checks
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence shift_edge_s;
        sclk_rise && clr_n;
    endsequence

    sequence latch_only_s;
        lclk_rise && clr_n && !sclk_rise;
    endsequence

    sequence held_on_s;
        clr_n && !en_n;
    endsequence

    shift_in_a: assert property (shift_edge_s |=> st_r.shreg[0] == $past(sdi)
                                 && st_r.shreg[7:1] == $past(st_r.shreg[6:0]))
        else $error("shift stage did not load or move");

    shift_hold_a: assert property (!sclk_rise && clr_n |=> st_r.shreg == $past(st_r.shreg))
        else $error("shift register moved without an edge");

    latch_copy_a: assert property (lclk_rise && clr_n |=> st_r.latch == $past(st_r.shreg))
        else $error("latch did not copy the shift stages");

    clear_all_a: assert property (!clr_n |=> st_r.shreg == 8'h00 && st_r.latch == 8'h00
                                  && st_r.crc == 6'h00)
        else $error("clear left a register set");

    clear_gate_a: assert property (!clr_n |=> sink_output_oe_o == 8'h00)
        else $error("sinks drove while clear was low");

    drive_en_a: assert property (held_on_s |=> sink_output_oe_o == $past(st_r.latch))
        else $error("sinks do not follow the latch");

    drive_off_a: assert property (en_n |=> sink_output_oe_o == 8'h00)
        else $error("sinks on while enable high");

    cascade_a: assert property (##1 cascade_output_o == $past(st_r.shreg[7]))
        else $error("cascade output is not the last stage");

    rb_push_a: assert property (lclk_rise && rb_mode && clr_n && !st_r.rb_pend
                                |=> st_r.rb_pend && st_r.rb_word == $past(st_r.crc)
                                ##[1:300] readback_valid_o)
        else $error("read-back remainder not offered");

    byte_out_a: assert property (latch_only_s ##1 held_on_s
                                 |=> sink_output_oe_o == $past(st_r.shreg, 2))
        else $error("shifted byte did not reach the sinks");

endmodule
`default_nettype wire

// ### sim/sld_host.sv
// Host model that drives the serial link pins of the sink driver.
// Assumes the core clock only paces pin changes; link period is 80 ns.
`timescale 1ns/100ps
`default_nettype none
module sld_host (
    // Pacing clock
    input  wire logic core_clk_i,
    // Link pins
    output logic      shift_clock_o,
    output logic      shift_data_o,
    output logic      latch_clock_o,
    output logic      clear_n_o,
    output logic      enable_n_o,
    output logic      mode_o
);
    initial begin
        shift_clock_o = 1'b0;
        shift_data_o  = 1'b0;
        latch_clock_o = 1'b0;
        clear_n_o     = 1'b1;
        enable_n_o    = 1'b0;
        mode_o        = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // =========
    // Pin tasks
    task automatic send_bit(input logic d);
        shift_data_o = d;
        wait_cyc(4);
        shift_clock_o = 1'b1;
        wait_cyc(2);
        // Hold time over, line no longer valid
        shift_data_o = ~d;
        wait_cyc(2);
        shift_clock_o = 1'b0;
    endtask

    task automatic pulse_latch(input logic rb);
        mode_o = rb;
        wait_cyc(4);
        latch_clock_o = 1'b1;
        wait_cyc(4);
        latch_clock_o = 1'b0;
        mode_o = 1'b0;
        wait_cyc(4);
    endtask

    task automatic set_levels(input logic clr_n, input logic en_n);
        clear_n_o  = clr_n;
        enable_n_o = en_n;
        wait_cyc(8);
    endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the serial-in latched sink driver.
// Assumes sld_host drives the link pins and the bench drains read-back.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                      core_clk_i;
    logic                      sys_rst_i;
    logic                      sclk, sdi, lclk, clr_n, en_n, rbm, casc, rb_valid, rb_ready;
    logic [sld_pkg::SR_W-1:0]  sink, sink_oe, exp_sr, exp_latch;
    logic [sld_pkg::CRC_W-1:0] rb_data, exp_crc;
    logic [sld_pkg::CRC_W-1:0] exp_q[$];
    int                        bad_count = 0;
    int                        num_checks = 0;

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    sld_host sld_host_i (.core_clk_i(core_clk_i), .shift_clock_o(sclk), .shift_data_o(sdi),
        .latch_clock_o(lclk), .clear_n_o(clr_n), .enable_n_o(en_n), .mode_o(rbm));

    sld_top sld_top_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .shift_clock_i(sclk),
        .shift_data_input_i(sdi), .latch_clock_i(lclk), .register_clear_n_i(clr_n),
        .drive_enable_n_i(en_n), .readback_mode_i(rbm), .cascade_output_o(casc),
        .sink_output_o(sink), .sink_output_oe_o(sink_oe), .readback_data_o(rb_data),
        .readback_valid_o(rb_valid), .readback_ready_i(rb_ready));

    // =========
    // Shared tasks
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic shift_byte(input logic [7:0] b);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            sld_host_i.send_bit(b[i]);
            if (clr_n) begin
                fb = exp_crc[5] ^ b[i];
                exp_crc = {exp_crc[4:0], 1'b0} ^ (fb ? sld_pkg::CRC_POLY : 6'h00);
                exp_sr = {exp_sr[6:0], b[i]};
            end
            check("cascade", {7'h00, exp_sr[7]}, {7'h00, casc});
        end
        check("sinks held", en_n ? 8'h00 : exp_latch, sink_oe);
    endtask

    task automatic latch(input logic rb);
        sld_host_i.pulse_latch(rb);
        exp_latch = exp_sr;
        if (rb && clr_n) begin
            exp_q.push_back(exp_crc);
            exp_crc = 6'h00;
        end
        check("sinks on", en_n ? 8'h00 : exp_latch, sink_oe);
        check("sink level", 8'h00, sink);
    endtask

    task automatic levels(input logic clr, input logic en);
        sld_host_i.set_levels(clr, en);
        if (!clr) begin
            exp_sr = 8'h00;
            exp_latch = 8'h00;
            exp_crc = 6'h00;
        end
        check("sinks on", (clr && !en) ? exp_latch : 8'h00, sink_oe);
        check("cascade", {7'h00, exp_sr[7]}, {7'h00, casc});
    endtask

    task automatic drain_one();
        int n;
        n = 0;
        while (rb_valid !== 1'b1 && n < 20) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        if (rb_valid !== 1'b1) begin
            bad_count++;
            $display("unexpected readback valid: expected 1 seen %b", rb_valid);
            wrap_up();
        end
        check("readback word", {2'h0, exp_q.pop_front()}, {2'h0, rb_data});
        rb_ready = 1'b1;
        @(posedge core_clk_i);
        #1;
        rb_ready = 1'b0;
        @(posedge core_clk_i);
        #1;
    endtask

    // =========
    // Scenarios
    task automatic test_load();
        shift_byte(8'hA5);
        latch(1'b0);
        shift_byte(8'h3C);
        latch(1'b0);
        $display("test_load done");
    endtask

    task automatic test_enable_clear();
        levels(1'b1, 1'b1);
        levels(1'b1, 1'b0);
        levels(1'b0, 1'b0);
        shift_byte(8'hFF);
        latch(1'b0);
        levels(1'b1, 1'b0);
        latch(1'b0);
        $display("test_enable_clear done");
    endtask

    task automatic test_readback();
        shift_byte(8'hA5);
        latch(1'b1);
        shift_byte(8'h5A);
        latch(1'b1);
        drain_one();
        drain_one();
        repeat (3) @(posedge core_clk_i);
        #1;
        check("readback valid", 8'h00, {7'h00, rb_valid});
        $display("test_readback done");
    endtask

    initial begin
        sys_rst_i = 1'b1;
        rb_ready = 1'b0;
        exp_sr = 8'h00;
        exp_latch = 8'h00;
        exp_crc = 6'h00;
        repeat (4) @(posedge core_clk_i);
        #1;
        sys_rst_i = 1'b0;
        repeat (4) @(posedge core_clk_i);
        #1;
        test_load();
        test_enable_clear();
        test_readback();
        wrap_up();
    end
endmodule
`default_nettype wire
